// ==== ccg_map.svh ====
`ifndef CCG_MAP_SVH
`define CCG_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CCG_OFF_CTRL 8'h00
`define CCG_OFF_STAT 8'h04
`define CCG_OFF_OWN_LO 8'h08
`define CCG_OFF_OWN_HI 8'h0C
`define CCG_OFF_PEER_LO 8'h10
`define CCG_OFF_PEER_HI 8'h14
`define CCG_OFF_EXT 8'h18
`define CCG_OFF_RXL_LO 8'h1C
`define CCG_OFF_RXL_HI 8'h20
`define CCG_OFF_RTT_LO 8'h24
`define CCG_OFF_RTT_HI 8'h28
`define CCG_OFF_LTIME 8'h2C
`define CCG_OFF_CNT_HI 8'h30
`define CCG_OFF_RXC_LO 8'h34
`define CCG_OFF_TBL_IDX 8'h38
`define CCG_OFF_TBL_LO 8'h3C
`define CCG_OFF_TBL_HI 8'h40
// ----------------------------------------
// Control and status fields
// ----------------------------------------
`define CCG_CTRL_ROLE 0
`define CCG_CTRL_DERIVE 1
`define CCG_CTRL_EXT_LD 2
`define CCG_CTRL_RX_LD 3
`define CCG_STAT_MISMATCH 0
// ----------------------------------------
// Widths and IV layout
// ----------------------------------------
`define CCG_CNT_W 48
`define CCG_LT_W 32
`define CCG_MARK_W 6
`define CCG_BLK_W 24
`define CCG_TBL_AW 6
`define CCG_IV_DIR 127
`define CCG_IV_MAC_LSB 72
`define CCG_IV_TIME_LSB 24
// ----------------------------------------
// Reset values
// ----------------------------------------
`define CCG_RST_CTRL 4'h0
`define CCG_RST_MAC 48'h0000_0000_0000
`define CCG_RST_CNT 48'h0000_0000_0000
`define CCG_RST_W32 32'h0000_0000
`define CCG_RST_W16 16'h0000
`define CCG_RST_IV 128'h0000_0000_0000_0000_0000_0000_0000_0000
`endif

// ==== ccg_pkg.sv ====
package ccg_pkg;
  typedef enum logic {
    CCG_ROLE_OLT,
    CCG_ROLE_ONU
  } ccg_role_t;
  typedef enum {
    CCG_DEC_IDLE,
    CCG_DEC_LOOK
  } ccg_dec_state_t;
endpackage

// ==== ccg_mac_mem.sv ====
`timescale 1ns/1ps
`include "ccg_map.svh"
module ccg_mac_mem (
  input wire logic ref_clk_i,
  input wire logic ce_i,
  input wire logic wr_en_i,
  input wire logic [`CCG_TBL_AW-1:0] wr_addr_i,
  input wire logic [`CCG_CNT_W-1:0] wr_data_i,
  input wire logic [`CCG_TBL_AW-1:0] rd_addr_i,
  output logic [`CCG_CNT_W-1:0] rd_data_o
);
  // ----------------------------------------
  // Station address table with registered read.
  // ----------------------------------------
  logic [`CCG_CNT_W-1:0] mem_q [0:(1<<`CCG_TBL_AW)-1];

  always_ff @(posedge ref_clk_i) begin
    if (ce_i) begin
      if (wr_en_i) begin
        mem_q[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem_q[rd_addr_i];
    end
  end
endmodule

// ==== ccg_top.sv ====
`timescale 1ns/1ps
`include "ccg_map.svh"
// Function
// [R1] Each cipher counter is 48 bits and steps with local time, kept apart.
// [R2] The OLT uses one cipher counter for both encryption and decryption vectors.
// [R3] The ONU keeps a transmit counter and a separate receive counter.
// [R4] Local time is 32 bits and increments once per envelope quantum.
// [R5] OLT cipher counter is a 16-bit extension above local time.
// [R6] Local time carry increments bit 32 of the cipher counter.
// [R7] ONU transmit counter extends ONU local time the same way.
// [R8] ONU receive counter is a separate 48-bit counter stepping with local time.
// [R9] Receive counter origin lags the OLT counter by downstream delay.
// [R10] ONU local time leads OLT local time by upstream delay.
// [R11] A transmitter puts local time bits 5 to 0 into the position marker.
// [R12] OLT reads receive buffer row when local time bits 5 to 0 match.
// [R13] ONU reads receive buffer row when receive counter low bits match.
// [R14] Upstream: ONU latches at transmit write, OLT at receive read.
// [R15] Downstream: OLT latches at transmit write, ONU at receive read.
// [R16] OLT may keep local time and cipher counter in one register.
// [R17] ONU may derive receive counter as transmit counter minus round trip.
// [R18] Vector building ends within one quantum so marker still matches.
// [R19] OLT encryption vector: channel, own address, counter, block zero.
// [R20] OLT decryption vector: looked-up address by LLID, counter, block zero.
// [R21] ONU builds encryption vector when header seen on transmit channel.
// [R22] ONU encryption vector: own address, transmit counter, block zero.
// [R23] ONU decryption vector: OLT address, receive counter, block zero.
// [R24] Bit 127 gives direction, bits 126 to 120 the channel number.
// [R25] Block index increments by one per further counter block.
// [R26] Counters wrap at 2**48; extension start value loads from software.
module ccg_top
  import ccg_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic eq_tick_i,
  input wire logic time_load_i,
  input wire logic [`CCG_LT_W-1:0] time_value_i,
  input wire logic tx_hdr_i,
  input wire logic [6:0] tx_ch_i,
  input wire logic rx_hdr_i,
  input wire logic [6:0] rx_ch_i,
  input wire logic [`CCG_MARK_W-1:0] rx_marker_i,
  input wire logic [15:0] rx_llid_i,
  input wire logic enc_blk_adv_i,
  input wire logic dec_blk_adv_i,
  output logic [`CCG_MARK_W-1:0] tx_marker_o,
  output logic [`CCG_MARK_W-1:0] rx_row_o,
  output logic [`CCG_LT_W-1:0] local_time_o,
  output logic [127:0] enc_iv_o,
  output logic enc_iv_valid_o,
  output logic [127:0] dec_iv_o,
  output logic dec_iv_valid_o
);
  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [127:0] build_iv(input logic dir, input logic [6:0] ch,
                                            input logic [47:0] mac, input logic [47:0] tm);
    logic [127:0] v;
    v = `CCG_RST_IV;
    v[`CCG_IV_DIR] = dir; // [R24]
    v[126:120] = ch; // [R24]
    v[`CCG_IV_MAC_LSB +: 48] = mac;
    v[`CCG_IV_TIME_LSB +: 48] = tm;
    v[`CCG_BLK_W-1:0] = `CCG_BLK_W'(0);
    return v;
  endfunction

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic [3:0] ctrl_q, ctrl_d;
  logic stat_q, stat_d;
  logic [47:0] own_mac_q, own_mac_d, peer_mac_q, peer_mac_d;
  logic [15:0] ext_q, ext_d;
  logic [47:0] rx_load_q, rx_load_d, rtt_q, rtt_d;
  logic [`CCG_TBL_AW-1:0] tbl_idx_q, tbl_idx_d;
  logic [31:0] tbl_lo_q, tbl_lo_d;
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic req, wr_go;
  logic ext_ld, rx_ld, tbl_wr, mismatch;
  logic [47:0] cnt_q, cnt_d, rxc_q, rxc_d, rx_eff;
  ccg_role_t role;

  assign role = ccg_role_t'(ctrl_q[`CCG_CTRL_ROLE]);
  assign req = avs_read_i | avs_write_i;
  assign wr_go = avs_write_i & ~wait_q;

  always_comb begin
    ctrl_d = ctrl_q;
    own_mac_d = own_mac_q;
    peer_mac_d = peer_mac_q;
    ext_d = ext_q;
    rx_load_d = rx_load_q;
    rtt_d = rtt_q;
    tbl_idx_d = tbl_idx_q;
    tbl_lo_d = tbl_lo_q;
    stat_d = stat_q;
    ext_ld = 1'b0;
    rx_ld = 1'b0;
    tbl_wr = 1'b0;
    wait_d = 1'b1;
    rdata_d = rdata_q;
    if (req && wait_q) begin
      wait_d = 1'b0;
      rdata_d = `CCG_RST_W32;
      if (avs_address_i == `CCG_OFF_CTRL) begin
        rdata_d = {28'h000_0000, ctrl_q[3:2] & 2'b00, ctrl_q[1:0]};
      end else if (avs_address_i == `CCG_OFF_STAT) begin
        rdata_d = {31'h0000_0000, stat_q};
      end else if (avs_address_i == `CCG_OFF_OWN_LO) begin
        rdata_d = own_mac_q[31:0];
      end else if (avs_address_i == `CCG_OFF_OWN_HI) begin
        rdata_d = {16'h0000, own_mac_q[47:32]};
      end else if (avs_address_i == `CCG_OFF_PEER_LO) begin
        rdata_d = peer_mac_q[31:0];
      end else if (avs_address_i == `CCG_OFF_PEER_HI) begin
        rdata_d = {16'h0000, peer_mac_q[47:32]};
      end else if (avs_address_i == `CCG_OFF_EXT) begin
        rdata_d = {16'h0000, ext_q};
      end else if (avs_address_i == `CCG_OFF_RXL_LO) begin
        rdata_d = rx_load_q[31:0];
      end else if (avs_address_i == `CCG_OFF_RXL_HI) begin
        rdata_d = {16'h0000, rx_load_q[47:32]};
      end else if (avs_address_i == `CCG_OFF_RTT_LO) begin
        rdata_d = rtt_q[31:0];
      end else if (avs_address_i == `CCG_OFF_RTT_HI) begin
        rdata_d = {16'h0000, rtt_q[47:32]};
      end else if (avs_address_i == `CCG_OFF_LTIME) begin
        rdata_d = cnt_q[31:0];
      end else if (avs_address_i == `CCG_OFF_CNT_HI) begin
        rdata_d = {rx_eff[47:32], cnt_q[47:32]};
      end else if (avs_address_i == `CCG_OFF_RXC_LO) begin
        rdata_d = rx_eff[31:0];
      end else if (avs_address_i == `CCG_OFF_TBL_IDX) begin
        rdata_d = {26'h000_0000, tbl_idx_q};
      end else if (avs_address_i == `CCG_OFF_TBL_LO) begin
        rdata_d = tbl_lo_q;
      end
    end
    if (wr_go) begin
      if (avs_address_i == `CCG_OFF_CTRL) begin
        ctrl_d = 4'(be_merge({28'h000_0000, ctrl_q}, avs_writedata_i, avs_byteenable_i));
        ext_ld = avs_byteenable_i[0] & avs_writedata_i[`CCG_CTRL_EXT_LD]; // [R26]
        rx_ld = avs_byteenable_i[0] & avs_writedata_i[`CCG_CTRL_RX_LD];
        ctrl_d[3:2] = 2'b00;
      end else if (avs_address_i == `CCG_OFF_STAT) begin
        if (avs_byteenable_i[0] && avs_writedata_i[`CCG_STAT_MISMATCH]) begin
          stat_d = 1'b0;
        end
      end else if (avs_address_i == `CCG_OFF_OWN_LO) begin
        own_mac_d[31:0] = be_merge(own_mac_q[31:0], avs_writedata_i, avs_byteenable_i);
      end else if (avs_address_i == `CCG_OFF_OWN_HI) begin
        own_mac_d[47:32] = 16'(be_merge({16'h0000, own_mac_q[47:32]}, avs_writedata_i, avs_byteenable_i));
      end else if (avs_address_i == `CCG_OFF_PEER_LO) begin
        peer_mac_d[31:0] = be_merge(peer_mac_q[31:0], avs_writedata_i, avs_byteenable_i);
      end else if (avs_address_i == `CCG_OFF_PEER_HI) begin
        peer_mac_d[47:32] = 16'(be_merge({16'h0000, peer_mac_q[47:32]}, avs_writedata_i, avs_byteenable_i));
      end else if (avs_address_i == `CCG_OFF_EXT) begin
        ext_d = 16'(be_merge({16'h0000, ext_q}, avs_writedata_i, avs_byteenable_i));
      end else if (avs_address_i == `CCG_OFF_RXL_LO) begin
        rx_load_d[31:0] = be_merge(rx_load_q[31:0], avs_writedata_i, avs_byteenable_i);
      end else if (avs_address_i == `CCG_OFF_RXL_HI) begin
        rx_load_d[47:32] = 16'(be_merge({16'h0000, rx_load_q[47:32]}, avs_writedata_i, avs_byteenable_i));
      end else if (avs_address_i == `CCG_OFF_RTT_LO) begin
        rtt_d[31:0] = be_merge(rtt_q[31:0], avs_writedata_i, avs_byteenable_i);
      end else if (avs_address_i == `CCG_OFF_RTT_HI) begin
        rtt_d[47:32] = 16'(be_merge({16'h0000, rtt_q[47:32]}, avs_writedata_i, avs_byteenable_i));
      end else if (avs_address_i == `CCG_OFF_TBL_IDX) begin
        tbl_idx_d = 6'(be_merge({26'h000_0000, tbl_idx_q}, avs_writedata_i, avs_byteenable_i));
      end else if (avs_address_i == `CCG_OFF_TBL_LO) begin
        tbl_lo_d = be_merge(tbl_lo_q, avs_writedata_i, avs_byteenable_i);
      end else if (avs_address_i == `CCG_OFF_TBL_HI) begin
        tbl_wr = 1'b1;
      end
    end
    if (mismatch) begin
      stat_d = 1'b1; // [R18]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_q <= `CCG_RST_CTRL;
      stat_q <= 1'b0;
      own_mac_q <= `CCG_RST_MAC;
      peer_mac_q <= `CCG_RST_MAC;
      ext_q <= `CCG_RST_W16;
      rx_load_q <= `CCG_RST_CNT;
      rtt_q <= `CCG_RST_CNT;
      tbl_idx_q <= 6'h00;
      tbl_lo_q <= `CCG_RST_W32;
      wait_q <= 1'b1;
      rdata_q <= `CCG_RST_W32;
    end else if (ce_i) begin
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      own_mac_q <= own_mac_d;
      peer_mac_q <= peer_mac_d;
      ext_q <= ext_d;
      rx_load_q <= rx_load_d;
      rtt_q <= rtt_d;
      tbl_idx_q <= tbl_idx_d;
      tbl_lo_q <= tbl_lo_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o = rdata_q;

  // ----------------------------------------
  // Cipher counters
  // ----------------------------------------
  logic [5:0] txm_q, txm_d, row_q, row_d;

  // The derived receive counter follows the transmit counter at a fixed distance.
  assign rx_eff = ctrl_q[`CCG_CTRL_DERIVE] ? (cnt_q - rtt_q) : rxc_q; // [R17]

  always_comb begin
    cnt_d = cnt_q;
    rxc_d = rxc_q;
    if (eq_tick_i) begin
      cnt_d = cnt_q + 48'h0000_0000_0001; // [R1] [R4] [R6] [R16]
      rxc_d = rxc_q + 48'h0000_0000_0001; // [R3] [R8]
    end
    if (time_load_i) begin
      cnt_d[31:0] = time_value_i; // [R5] [R7] [R10]
    end
    if (ext_ld) begin
      cnt_d[47:32] = ext_q; // [R26]
    end
    if (rx_ld) begin
      rxc_d = rx_load_q; // [R9]
    end
    txm_d = cnt_d[5:0]; // [R11]
    if (role == CCG_ROLE_ONU) begin
      row_d = ctrl_q[`CCG_CTRL_DERIVE] ? 6'(cnt_d[5:0] - rtt_q[5:0]) : rxc_d[5:0]; // [R13]
    end else begin
      row_d = cnt_d[5:0]; // [R12]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_q <= `CCG_RST_CNT;
      rxc_q <= `CCG_RST_CNT;
      txm_q <= 6'h00;
      row_q <= 6'h00;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
      rxc_q <= rxc_d;
      txm_q <= txm_d;
      row_q <= row_d;
    end
  end

  assign tx_marker_o = txm_q;
  assign rx_row_o = row_q;
  assign local_time_o = cnt_q[31:0];

  // ----------------------------------------
  // Decrypt lookup stage
  // ----------------------------------------
  ccg_dec_state_t dec_st_q, dec_st_d;
  logic [47:0] dec_tm_q, dec_tm_d, tbl_rdata;
  logic [6:0] dec_ch_q, dec_ch_d;

  ccg_mac_mem u_mac_mem (
    .ref_clk_i(ref_clk_i),
    .ce_i(ce_i),
    .wr_en_i(tbl_wr),
    .wr_addr_i(tbl_idx_q),
    .wr_data_i({avs_writedata_i[15:0], tbl_lo_q}),
    .rd_addr_i(rx_llid_i[5:0]),
    .rd_data_o(tbl_rdata)
  );

  always_comb begin
    dec_st_d = dec_st_q;
    dec_tm_d = dec_tm_q;
    dec_ch_d = dec_ch_q;
    mismatch = 1'b0;
    case (dec_st_q)
      CCG_DEC_IDLE: begin
        if (rx_hdr_i) begin
          dec_st_d = CCG_DEC_LOOK;
        end
      end
      CCG_DEC_LOOK: begin
        if (!rx_hdr_i) begin
          dec_st_d = CCG_DEC_IDLE;
        end
      end
      default: begin
        dec_st_d = CCG_DEC_IDLE;
      end
    endcase
    if (rx_hdr_i) begin
      dec_tm_d = (role == CCG_ROLE_ONU) ? rx_eff : cnt_q; // [R2] [R14] [R15]
      dec_ch_d = rx_ch_i;
      mismatch = ((role == CCG_ROLE_ONU) ? rx_eff[5:0] : cnt_q[5:0]) != rx_marker_i; // [R18]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      dec_st_q <= CCG_DEC_IDLE;
      dec_tm_q <= `CCG_RST_CNT;
      dec_ch_q <= 7'h00;
    end else if (ce_i) begin
      dec_st_q <= dec_st_d;
      dec_tm_q <= dec_tm_d;
      dec_ch_q <= dec_ch_d;
    end
  end

  // ----------------------------------------
  // Vector outputs
  // ----------------------------------------
  logic [1:0] start, adv;
  logic [127:0] seed [0:1];
  logic [127:0] iv_q [0:1];
  logic [1:0] val_q;

  assign start[0] = tx_hdr_i; // [R21]
  assign start[1] = dec_st_q == CCG_DEC_LOOK;
  assign adv = {dec_blk_adv_i, enc_blk_adv_i};
  assign seed[0] = build_iv(role == CCG_ROLE_ONU, tx_ch_i, own_mac_q, cnt_q); // [R19] [R22] [R14] [R15]
  assign seed[1] = build_iv(role == CCG_ROLE_OLT, dec_ch_q,
                            (role == CCG_ROLE_ONU) ? peer_mac_q : tbl_rdata, dec_tm_q); // [R20] [R23]

  for (genvar i = 0; i < 2; i++) begin : g_path
    logic [127:0] iv_d;
    logic val_d;

    always_comb begin
      iv_d = iv_q[i];
      val_d = 1'b0;
      if (start[i]) begin
        iv_d = seed[i];
        val_d = 1'b1;
      end else if (adv[i]) begin
        iv_d[`CCG_BLK_W-1:0] = iv_q[i][`CCG_BLK_W-1:0] + `CCG_BLK_W'(1); // [R25]
        val_d = 1'b1;
      end
    end

    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        iv_q[i] <= `CCG_RST_IV;
        val_q[i] <= 1'b0;
      end else if (ce_i) begin
        iv_q[i] <= iv_d;
        val_q[i] <= val_d;
      end
    end
  end

  assign enc_iv_o = iv_q[0];
  assign enc_iv_valid_o = val_q[0];
  assign dec_iv_o = iv_q[1];
  assign dec_iv_valid_o = val_q[1];
endmodule

// ==== ccg_top_properties.sv ====
`timescale 1ns/1ps
`include "ccg_map.svh"
module ccg_props (
  input logic ref_clk_i,
  input logic rst_i,
  input logic ce_i,
  input logic avs_read_i,
  input logic avs_write_i,
  input logic avs_waitrequest_o,
  input logic eq_tick_i,
  input logic time_load_i,
  input logic [`CCG_LT_W-1:0] time_value_i,
  input logic tx_hdr_i,
  input logic [6:0] tx_ch_i,
  input logic rx_hdr_i,
  input logic [6:0] rx_ch_i,
  input logic enc_blk_adv_i,
  input logic dec_blk_adv_i,
  input logic [`CCG_MARK_W-1:0] tx_marker_o,
  input logic [`CCG_LT_W-1:0] local_time_o,
  input logic [127:0] enc_iv_o,
  input logic enc_iv_valid_o,
  input logic [127:0] dec_iv_o,
  input logic dec_iv_valid_o
);
  // ----------------------------------------
  // Timing checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i || !ce_i);
  sequence enc_ready_s;
    ##1 enc_iv_valid_o && enc_iv_o[126:120] == $past(tx_ch_i) &&
      enc_iv_o[55:24] == $past(local_time_o) && enc_iv_o[23:0] == 24'h00_0000;
  endsequence
  sequence dec_ready_s;
    ##2 dec_iv_valid_o && dec_iv_o[126:120] == $past(rx_ch_i, 2) && dec_iv_o[23:0] == 24'h00_0000;
  endsequence
  wait_drop_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("Bus wait did not end after one cycle.");
  tick_step_a: assert property (eq_tick_i && !time_load_i |=> local_time_o == $past(local_time_o) + 32'h1)
    else $error("Local time did not step by one.");
  time_load_a: assert property (time_load_i && !eq_tick_i |=> local_time_o == $past(time_value_i))
    else $error("Local time was not loaded.");
  time_hold_a: assert property (!time_load_i && !eq_tick_i |=> $stable(local_time_o))
    else $error("Local time moved without a quantum.");
  marker_src_a: assert property (tx_marker_o == local_time_o[5:0])
    else $error("Transmit marker differs from local time.");
  enc_iv_a: assert property (tx_hdr_i |-> enc_ready_s)
    else $error("Encryption vector wrong after header.");
  enc_pulse_a: assert property (enc_iv_valid_o == $past(tx_hdr_i || enc_blk_adv_i))
    else $error("Encryption valid does not follow header or advance.");
  enc_hold_a: assert property (!tx_hdr_i && !enc_blk_adv_i |=> $stable(enc_iv_o))
    else $error("Encryption vector changed unprompted.");
  enc_block_a: assert property (enc_blk_adv_i && !tx_hdr_i |=> enc_iv_o == $past(enc_iv_o) + 128'h1)
    else $error("Encryption block index did not step.");
  dec_iv_a: assert property (rx_hdr_i |-> dec_ready_s)
    else $error("Decryption vector wrong after header.");
  dec_block_a: assert property (dec_blk_adv_i && !$past(rx_hdr_i) |=> dec_iv_o == $past(dec_iv_o) + 128'h1)
    else $error("Decryption block index did not step.");
endmodule
bind ccg_top ccg_props i_props (.*);

// ==== ccg_peer_model.sv ====
`timescale 1ns/1ps
module ccg_peer_model (
  input logic ref_clk_i,
  input logic rst_i,
  input logic eq_tick_i,
  input logic load_i,
  input logic [31:0] time_i,
  input logic send_i,
  input logic bad_i,
  input logic [6:0] ch_i,
  input logic [15:0] llid_i,
  output logic hdr_o,
  output logic [6:0] ch_o,
  output logic [5:0] marker_o,
  output logic [15:0] llid_o
);
  // ----------------------------------------
  // Peer station header source
  // ----------------------------------------
  logic [31:0] time_q;
  initial begin
    hdr_o = 1'b0;
    ch_o = 7'h00;
    marker_o = 6'h00;
    llid_o = 16'h0000;
  end
  always @(posedge ref_clk_i) begin
    time_q <= rst_i ? 32'h0000_0000 : load_i ? time_i : time_q + {31'h0000_0000, eq_tick_i};
    hdr_o <= send_i && !rst_i;
    if (send_i) begin
      ch_o <= ch_i;
      llid_o <= llid_i;
      marker_o <= time_q[5:0] ^ {5'h00, bad_i};
    end else if (hdr_o) begin
      ch_o <= ~ch_o;
      llid_o <= ~llid_o;
      marker_o <= ~marker_o;
    end
  end
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
`include "ccg_map.svh"
module tb;
  logic ref_clk_i, rst_i, ce_i, avs_read_i, avs_write_i, avs_waitrequest_o, eq_tick_i, time_load_i;
  logic tx_hdr_i, rx_hdr_i, enc_blk_adv_i, dec_blk_adv_i, enc_iv_valid_o, dec_iv_valid_o;
  logic p_load, p_send, p_bad;
  logic [7:0] avs_address_i;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, time_value_i, local_time_o, q;
  logic [6:0] tx_ch_i, rx_ch_i, p_ch;
  logic [5:0] rx_marker_i, tx_marker_o, rx_row_o;
  logic [15:0] rx_llid_i, p_llid, ext;
  logic [127:0] enc_iv_o, dec_iv_o;
  logic [47:0] cnt, rxc, own, peer, tmac;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  // ----------------------------------------
  // Design, peer and helpers
  // ----------------------------------------
  ccg_top i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .eq_tick_i(eq_tick_i), .time_load_i(time_load_i), .time_value_i(time_value_i), .tx_hdr_i(tx_hdr_i),
    .tx_ch_i(tx_ch_i), .rx_hdr_i(rx_hdr_i), .rx_ch_i(rx_ch_i), .rx_marker_i(rx_marker_i), .rx_llid_i(rx_llid_i),
    .enc_blk_adv_i(enc_blk_adv_i), .dec_blk_adv_i(dec_blk_adv_i), .tx_marker_o(tx_marker_o), .rx_row_o(rx_row_o),
    .local_time_o(local_time_o), .enc_iv_o(enc_iv_o), .enc_iv_valid_o(enc_iv_valid_o), .dec_iv_o(dec_iv_o),
    .dec_iv_valid_o(dec_iv_valid_o));
  ccg_peer_model i_peer (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .eq_tick_i(eq_tick_i), .load_i(p_load),
    .time_i(time_value_i), .send_i(p_send), .bad_i(p_bad), .ch_i(p_ch), .llid_i(p_llid),
    .hdr_o(rx_hdr_i), .ch_o(rx_ch_i), .marker_o(rx_marker_i), .llid_o(rx_llid_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      test_done();
    end
  end
  function automatic logic [127:0] iv(input logic d, input logic [6:0] c, input logic [47:0] m,
                                      input logic [47:0] t);
    return {d, c, m, t, 24'h00_0000};
  endfunction
  task automatic test_done();
    $display("Compared %0d, errors %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= d;
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(128'(q), 128'(e));
  endtask
  task automatic wr48(input logic [7:0] a, input logic [47:0] v);
    bus(1'b1, a, v[31:0]);
    bus(1'b1, a + 8'h04, {16'h0000, v[47:32]});
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      eq_tick_i <= 1'b1;
      cnt = cnt + 48'h1;
      rxc = rxc + 48'h1;
    end
    @(posedge ref_clk_i);
    eq_tick_i <= 1'b0;
  endtask
  task automatic set_time(input logic [31:0] v, input logic d, input logic p);
    @(posedge ref_clk_i);
    time_value_i <= v;
    time_load_i <= d;
    p_load <= p;
    @(posedge ref_clk_i);
    time_load_i <= 1'b0;
    p_load <= 1'b0;
    if (d) cnt[31:0] = v;
  endtask
  task automatic enc(input logic d);
    @(posedge ref_clk_i);
    tx_hdr_i <= 1'b1;
    tx_ch_i <= 7'($urandom);
    @(posedge ref_clk_i);
    tx_hdr_i <= 1'b0;
    @(posedge ref_clk_i);
    chk(128'(enc_iv_valid_o), 128'h1);
    chk(enc_iv_o, iv(d, tx_ch_i, own, cnt));
    enc_blk_adv_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    enc_blk_adv_i <= 1'b0;
    @(posedge ref_clk_i);
    chk(enc_iv_o, iv(d, tx_ch_i, own, cnt) + 128'h3);
  endtask
  task automatic dec(input logic d, input logic [47:0] m, input logic [47:0] t);
    @(posedge ref_clk_i);
    p_send <= 1'b1;
    p_ch <= 7'($urandom);
    @(posedge ref_clk_i);
    p_send <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk(128'(dec_iv_valid_o), 128'h1);
    chk(dec_iv_o, iv(d, p_ch, m, t));
    dec_blk_adv_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    dec_blk_adv_i <= 1'b0;
    @(posedge ref_clk_i);
    chk(dec_iv_o, iv(d, p_ch, m, t) + 128'h2);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_i, ce_i, avs_read_i, avs_write_i, eq_tick_i, time_load_i} = 6'b11_0000;
    {tx_hdr_i, enc_blk_adv_i, dec_blk_adv_i, p_load, p_send, p_bad} = 6'b00_0000;
    {avs_address_i, avs_writedata_i, time_value_i, tx_ch_i, p_ch} = '0;
    avs_byteenable_i = 4'hF;
    void'($urandom(25));
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    cnt = 48'h0;
    rxc = 48'h0;
    for (int a = 0; a <= 'h34; a += 4) rd(8'(a), 32'h0);
    bus(1'b1, 8'h44, 32'hFFFF_FFFF);
    rd(8'h44, 32'h0);
    own = {16'($urandom), 32'($urandom)};
    peer = {16'($urandom), 32'($urandom)};
    tmac = {16'($urandom), 32'($urandom)};
    p_llid = 16'($urandom);
    wr48(`CCG_OFF_OWN_LO, own);
    wr48(`CCG_OFF_PEER_LO, peer);
    bus(1'b1, `CCG_OFF_TBL_IDX, 32'(p_llid[5:0]));
    wr48(`CCG_OFF_TBL_LO, tmac);
    rd(`CCG_OFF_OWN_HI, 32'(own[47:32]));
    for (int i = 0; i < 2; i++) begin
      ext = i ? 16'hFFFF : 16'($urandom);
      bus(1'b1, `CCG_OFF_EXT, {16'h0000, ext});
      bus(1'b1, `CCG_OFF_CTRL, 32'h4);
      cnt[47:32] = ext;
      set_time(32'hFFFF_FFFE, 1'b1, 1'b1);
      tick(3);
      rd(`CCG_OFF_CNT_HI, {rxc[47:32], cnt[47:32]});
      rd(`CCG_OFF_LTIME, cnt[31:0]);
      tick($urandom_range(5, 1));
      enc(1'b0);
      chk(128'(rx_row_o), 128'(cnt[5:0]));
      dec(1'b1, tmac, cnt);
    end
    rd(`CCG_OFF_STAT, 32'h0);
    p_bad <= 1'b1;
    dec(1'b1, tmac, cnt);
    p_bad <= 1'b0;
    rd(`CCG_OFF_STAT, 32'h1);
    bus(1'b1, `CCG_OFF_STAT, 32'h1);
    rd(`CCG_OFF_STAT, 32'h0);
    rxc = {16'($urandom), 32'($urandom)};
    wr48(`CCG_OFF_RXL_LO, rxc);
    bus(1'b1, `CCG_OFF_CTRL, 32'h9);
    rd(`CCG_OFF_CTRL, 32'h1);
    set_time(rxc[31:0], 1'b0, 1'b1);
    tick($urandom_range(7, 1));
    rd(`CCG_OFF_RXC_LO, rxc[31:0]);
    rd(`CCG_OFF_CNT_HI, {rxc[47:32], cnt[47:32]});
    chk(128'(rx_row_o), 128'(rxc[5:0]));
    enc(1'b1);
    dec(1'b0, peer, rxc);
    ext = 16'($urandom);
    wr48(`CCG_OFF_RTT_LO, {32'h0000_0000, ext});
    bus(1'b1, `CCG_OFF_CTRL, 32'h3);
    rd(`CCG_OFF_RTT_LO, {16'h0000, ext});
    rxc = cnt - {32'h0000_0000, ext};
    rd(`CCG_OFF_RXC_LO, rxc[31:0]);
    chk(128'(rx_row_o), 128'(rxc[5:0]));
    set_time(rxc[31:0], 1'b0, 1'b1);
    dec(1'b0, peer, rxc);
    ce_i <= 1'b0;
    tick(2);
    @(posedge ref_clk_i);
    ce_i <= 1'b1;
    rd(`CCG_OFF_LTIME, cnt[31:0] - 32'h0000_0002);
    test_done();
  end
endmodule
